/* File: hdl/ifsb_bank.sv */
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

`include "ifsb_regs.svh"

module ifsb_bank
#(
	parameter bit HAS_CAN   = 1'b1,
	parameter bit HAS_AUDIO = 1'b1
)
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	// Source requests, one-cycle pulses
	input  wire logic        calendar_clock_req,
	input  wire logic        dma_ch5_done_req,
	input  wire logic        codec_if_event_req,
	input  wire logic        codec_if_error_req,
	input  wire logic        audio_conv_left_req,
	input  wire logic        audio_conv_right_req,
	input  wire logic        can_transmit_req,
	input  wire logic        dma_ch7_done_req,
	input  wire logic        dma_ch6_done_req,
	input  wire logic        checksum_gen_req,
	input  wire logic        serial_port2_error_req,
	input  wire logic        serial_port1_error_req,
	// Pending flags
	output var  logic [15:0] interrupt_flags_word_three,
	output var  logic [15:0] interrupt_flags_word_four,
	// Interrupt
	output var  logic        irq
);

	// ****************************************************************
	// Functions.
	// ****************************************************************

	function automatic ifsb_pkg::ifsb_sel_type sel_of(input logic [11:0] addr);
		ifsb_pkg::ifsb_sel_type sel;
		case (addr)
			`IFSB_OFF_FLAGS3: sel = ifsb_pkg::SEL_FLAGS3;
			`IFSB_OFF_FLAGS4: sel = ifsb_pkg::SEL_FLAGS4;
			`IFSB_OFF_STATUS: sel = ifsb_pkg::SEL_STATUS;
			`IFSB_OFF_MASK:   sel = ifsb_pkg::SEL_MASK;
			default:          sel = ifsb_pkg::SEL_NONE;
		endcase
		return sel;
	endfunction : sel_of

	function automatic logic [15:0] impl_four(input logic can, input logic audio);
		logic [15:0] m;
		m = `IFSB_IMPL4_BASE;
		if (can)
			m = m | `IFSB_IMPL4_CAN;
		if (audio)
			m = m | `IFSB_IMPL4_AUDIO;
		return m;
	endfunction : impl_four

	// ****************************************************************
	// Declarations.
	// ****************************************************************

	localparam logic [15:0] IMPL3 = `IFSB_IMPL3;
	localparam logic [15:0] IMPL4 = impl_four(HAS_CAN, HAS_AUDIO);

	ifsb_pkg::ifsb_sel_type sel;
	logic                   setup;
	logic                   access;
	logic                   wr_access;
	logic                   rd_access;

	ifsb_pkg::ifsb_word_type set_vec [2];
	ifsb_pkg::ifsb_word_type flags   [2];
	logic [1:0]              flag_wr;
	logic [15:0]             flag_be;
	logic [31:0]             events;

	logic [31:0] status_q;
	logic [31:0] status_d;
	logic [31:0] mask_q;
	logic [31:0] rd_clr_q;
	logic [31:0] prdata_q;
	logic [31:0] rd_value;

	// ****************************************************************
	// APB decode.
	// ****************************************************************

	assign sel       = sel_of(paddr);
	assign setup     = psel & ~penable;
	assign access    = psel & penable;
	assign wr_access = access & pwrite;
	assign rd_access = access & ~pwrite;

	// Read data is taken at the setup edge, so the slave never waits.
	assign pready  = 1'b1;
	assign pslverr = access & (sel == ifsb_pkg::SEL_NONE);

	// ****************************************************************
	// Request mapping.
	// ****************************************************************

	always_comb
	begin
		set_vec[0] = '0;
		set_vec[1] = '0;
		set_vec[0][`IFSB_B3_CALENDAR]    = calendar_clock_req;
		set_vec[0][`IFSB_B3_DMA5_DONE]   = dma_ch5_done_req;
		set_vec[0][`IFSB_B3_CODEC_EVENT] = codec_if_event_req;
		set_vec[0][`IFSB_B3_CODEC_ERROR] = codec_if_error_req;
		set_vec[1][`IFSB_B4_AUDIO_LEFT]  = audio_conv_left_req & HAS_AUDIO;
		set_vec[1][`IFSB_B4_AUDIO_RIGHT] = audio_conv_right_req & HAS_AUDIO;
		set_vec[1][`IFSB_B4_CAN_TX]      = can_transmit_req & HAS_CAN;
		set_vec[1][`IFSB_B4_DMA7_DONE]   = dma_ch7_done_req;
		set_vec[1][`IFSB_B4_DMA6_DONE]   = dma_ch6_done_req;
		set_vec[1][`IFSB_B4_CHECKSUM]    = checksum_gen_req;
		set_vec[1][`IFSB_B4_UART2_ERROR] = serial_port2_error_req;
		set_vec[1][`IFSB_B4_UART1_ERROR] = serial_port1_error_req;
	end

	// ****************************************************************
	// Flag words.
	// ****************************************************************

	assign flag_wr[0] = wr_access & (sel == ifsb_pkg::SEL_FLAGS3);
	assign flag_wr[1] = wr_access & (sel == ifsb_pkg::SEL_FLAGS4);
	assign flag_be    = {{8{pstrb[1]}}, {8{pstrb[0]}}};

	generate
		for (genvar gi = 0; gi < 2; gi++)
		begin : g_word
			ifsb_flag_reg
			#(
				.WIDTH (16),
				.IMPL  ((gi == 0) ? IMPL3 : IMPL4)
			)
			u_flags
			(
				.pclk    (pclk),
				.presetn (presetn),
				.set_vec (set_vec[gi]),
				.wr_en   (flag_wr[gi]),
				.wr_be   (flag_be),
				.wr_data (pwdata[15:0]),
				.flags   (flags[gi])
			);
		end
	endgenerate

	assign interrupt_flags_word_three = flags[0];
	assign interrupt_flags_word_four  = flags[1];

	// ****************************************************************
	// Interrupt status and mask.
	// ****************************************************************

	// Every accepted source request is also an event for the summary output.
	assign events = {set_vec[1] & IMPL4, set_vec[0] & IMPL3};

	// Only bits that were returned by the read are cleared; new events win.
	always_comb
	begin
		status_d = status_q;
		if (rd_access && (sel == ifsb_pkg::SEL_STATUS))
			status_d = status_q & ~rd_clr_q;
		status_d = status_d | events;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			status_q <= `IFSB_RST_STATUS;
		else
			status_q <= status_d;
	end

	generate
		for (genvar bi = 0; bi < 4; bi++)
		begin : g_mask_lane
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					mask_q[bi*8 +: 8] <= 8'(`IFSB_RST_MASK >> (bi*8));
				else if (wr_access && (sel == ifsb_pkg::SEL_MASK) && pstrb[bi])
					mask_q[bi*8 +: 8] <= pwdata[bi*8 +: 8];
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(status_d & mask_q);
	end

	// ****************************************************************
	// Read path.
	// ****************************************************************

	always_comb
	begin
		case (sel)
			ifsb_pkg::SEL_FLAGS3: rd_value = {16'h0000, flags[0]};
			ifsb_pkg::SEL_FLAGS4: rd_value = {16'h0000, flags[1]};
			ifsb_pkg::SEL_STATUS: rd_value = status_q;
			ifsb_pkg::SEL_MASK:   rd_value = mask_q;
			default:              rd_value = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_q <= 32'h0000_0000;
		else if (setup && !pwrite)
			prdata_q <= rd_value;
	end

	// Remembers which status bits this read returned, so later ones survive.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rd_clr_q <= 32'h0000_0000;
		else if (setup)
			rd_clr_q <= (!pwrite && (sel == ifsb_pkg::SEL_STATUS)) ? status_q : 32'h0000_0000;
	end

	assign prdata = prdata_q;

endmodule : ifsb_bank

`default_nettype wire

/* File: inc/ifsb_regs.svh */
`ifndef IFSB_REGS_SVH
`define IFSB_REGS_SVH

// ****************************************************************
// Register byte offsets on the APB.
// ****************************************************************
`define IFSB_OFF_FLAGS3 12'h000
`define IFSB_OFF_FLAGS4 12'h004
`define IFSB_OFF_STATUS 12'h008
`define IFSB_OFF_MASK   12'h00c

// ****************************************************************
// Field positions in the third flag word.
// ****************************************************************
`define IFSB_B3_CALENDAR    14
`define IFSB_B3_DMA5_DONE   13
`define IFSB_B3_CODEC_EVENT 12
`define IFSB_B3_CODEC_ERROR 11

// ****************************************************************
// Field positions in the fourth flag word.
// ****************************************************************
`define IFSB_B4_AUDIO_LEFT  15
`define IFSB_B4_AUDIO_RIGHT 14
`define IFSB_B4_CAN_TX      6
`define IFSB_B4_DMA7_DONE   5
`define IFSB_B4_DMA6_DONE   4
`define IFSB_B4_CHECKSUM    3
`define IFSB_B4_UART2_ERROR 2
`define IFSB_B4_UART1_ERROR 1

// ****************************************************************
// Implemented bits and reset values.
// ****************************************************************
`define IFSB_IMPL3       16'h7800
`define IFSB_IMPL4_BASE  16'h003e
`define IFSB_IMPL4_CAN   16'h0040
`define IFSB_IMPL4_AUDIO 16'hc000
`define IFSB_RST_FLAGS   16'h0000
`define IFSB_RST_STATUS  32'h0000_0000
`define IFSB_RST_MASK    32'h0000_0000

`endif

/* File: inc/ifsb_pkg.sv */
`default_nettype none

package ifsb_pkg;

	// Register selected by an APB address.
	typedef enum logic [2:0]
	{
		SEL_FLAGS3,
		SEL_FLAGS4,
		SEL_STATUS,
		SEL_MASK,
		SEL_NONE
	} ifsb_sel_type;

	typedef logic [15:0] ifsb_word_type;

endpackage : ifsb_pkg

`default_nettype wire

/* File: hdl/ifsb_flag_reg.sv */
`timescale 1ns/100ps
`default_nettype none

module ifsb_flag_reg
#(
	parameter int               WIDTH = 16,
	parameter logic [WIDTH-1:0] IMPL  = '0
)
(
	// Clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// Hardware requests
	input  wire logic [WIDTH-1:0] set_vec,
	// Software write
	input  wire logic             wr_en,
	input  wire logic [WIDTH-1:0] wr_be,
	input  wire logic [WIDTH-1:0] wr_data,
	// Pending flags
	output var  logic [WIDTH-1:0] flags
);

	logic [WIDTH-1:0] flags_q;
	logic [WIDTH-1:0] flags_d;

	// A request in the same cycle as a clearing write still sets the flag.
	always_comb
	begin
		flags_d = flags_q;
		if (wr_en)
			flags_d = (flags_q & ~wr_be) | (wr_data & wr_be);
		flags_d = (flags_d | set_vec) & IMPL;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			flags_q <= '0;
		else
			flags_q <= flags_d;
	end

	assign flags = flags_q;

endmodule : ifsb_flag_reg

`default_nettype wire

/* File: dv/ifsb_bank_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module ifsb_bank_chk
#(
	parameter bit HAS_CAN = 1'b1
)
(
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic [11:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic        pslverr,
	// Sources
	input wire logic        calendar_clock_req,
	input wire logic        dma_ch5_done_req,
	input wire logic        codec_if_event_req,
	input wire logic        codec_if_error_req,
	input wire logic        audio_conv_right_req,
	input wire logic        checksum_gen_req,
	// Flags and interrupt
	input wire logic [15:0] interrupt_flags_word_three,
	input wire logic [15:0] interrupt_flags_word_four,
	input wire logic        irq
);
	wire logic [15:0] f3 = interrupt_flags_word_three;
	wire logic [15:0] f4 = interrupt_flags_word_four;
	wire logic        wr3 = psel && penable && pwrite && paddr == 12'h000;
	// An event alone, with the error flag clear and no write, must leave the error flag clear.
	wire logic        ev_only = codec_if_event_req && !codec_if_error_req && !f3[11] && !wr3;
	wire logic        clr13 = wr3 && pstrb[1] && !pwdata[13] && !dma_ch5_done_req;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_cal_flag_set: assert property (calendar_clock_req |=> f3[14])
		else $error("calendar flag not set");
	a_dma5_flag_set: assert property (dma_ch5_done_req |=> f3[13])
		else $error("dma5 flag not set");
	a_codec_ev_set: assert property (ev_only |=> f3[12] && !f3[11])
		else $error("codec event flag wrong");
	a_codec_err_set: assert property (codec_if_error_req |=> f3[11])
		else $error("codec error flag not set");
	a_unimpl_zero: assert property ((f3 & 16'h87ff) == 16'h0000)
		else $error("unused word three bit set");
	a_flag_holds: assert property (!wr3 |=> (f3 & $past(f3)) == $past(f3))
		else $error("flag fell without a write");
	a_can_idle: assert property (HAS_CAN || !f4[6])
		else $error("disabled can flag set");
	a_audio_r_set: assert property (audio_conv_right_req |=> f4[14])
		else $error("audio right flag not set");
	a_crc_flag_set: assert property (checksum_gen_req |=> f4[3])
		else $error("checksum flag not set");
	a_write_clears: assert property (clr13 |=> !f3[13])
		else $error("write of zero did not clear");
	c_cal: cover property (calendar_clock_req);
	c_irq: cover property ($rose(irq));
	c_err: cover property (pslverr);
endmodule : ifsb_bank_chk
`default_nettype wire

/* File: dv/ifsb_src_model.sv */
`timescale 1ns/100ps
`default_nettype none
module ifsb_src_model
(
	// Clock
	input  wire logic        pclk,
	// Requests to the bank
	output var  logic [11:0] req
);
	initial req = 12'h000;
	// Each request is a one-cycle pulse launched just after a rising edge.
	task pulse(input logic [11:0] m);
		@(posedge pclk);
		req <= m;
		@(posedge pclk);
		req <= 12'h000;
	endtask : pulse
endmodule : ifsb_src_model
`default_nettype wire

/* File: dv/interrupt_flag_status_bank_test.sv */
`timescale 1ns/100ps
`default_nettype none
module interrupt_flag_status_bank_test;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0]  pstrb = 4'hf;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic [11:0] req;
	logic [15:0] f3;
	logic [15:0] f4;
	logic [31:0] rd;
	logic        er;
	int          miscompares = 0;
	int          n_tests = 0;
	logic [31:0] tab [12] = '{32'h0000_4000, 32'h0000_2000, 32'h0000_1000, 32'h0000_0800,
		32'h8000_0000, 32'h4000_0000, 32'h0000_0000, 32'h0020_0000, 32'h0010_0000,
		32'h0008_0000, 32'h0004_0000, 32'h0002_0000};
	always #5 pclk = ~pclk;
	ifsb_src_model SRC (.pclk(pclk), .req(req));
	ifsb_bank #(.HAS_CAN(1'b0), .HAS_AUDIO(1'b1)) DUT (.pclk(pclk), .presetn(presetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.calendar_clock_req(req[0]), .dma_ch5_done_req(req[1]), .codec_if_event_req(req[2]),
		.codec_if_error_req(req[3]), .audio_conv_left_req(req[4]),
		.audio_conv_right_req(req[5]), .can_transmit_req(req[6]), .dma_ch7_done_req(req[7]),
		.dma_ch6_done_req(req[8]), .checksum_gen_req(req[9]),
		.serial_port2_error_req(req[10]), .serial_port1_error_req(req[11]),
		.interrupt_flags_word_three(f3), .interrupt_flags_word_four(f4), .irq(irq));
	task end_sim;
		$display("miscompares=%0d n_tests=%0d", miscompares, n_tests);
		if (miscompares == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim
	task chk_word(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e)
		begin
			miscompares++;
			$display("mismatch %0t word %h expected %h", $time, g, e);
		end
	endtask : chk_word
	task chk_bit(input logic g, input logic e);
		n_tests++;
		if (g !== e)
		begin
			miscompares++;
			$display("mismatch %0t bit %b expected %b", $time, g, e);
		end
	endtask : chk_bit
	task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rdc(input logic [11:0] a, input logic [31:0] e);
		apb(a, 1'b0, 32'h0000_0000);
		chk_word(rd, e);
	endtask : rdc
	task irqc(input logic e);
		#1;
		chk_bit(irq, e);
	endtask : irqc
	initial
	begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rdc(12'h000, 32'h0000_0000);
		rdc(12'h004, 32'h0000_0000);
		rdc(12'h00c, 32'h0000_0000);
		chk_bit(er, 1'b0);
		apb(12'h00c, 1'b1, 32'hffff_ffff);
		for (int i = 0; i < 12; i++)
		begin
			SRC.pulse(12'h001 << i);
			irqc(tab[i] != 32'h0000_0000);
			chk_word({f4, f3}, tab[i]);
			rdc(12'h008, tab[i]);
			irqc(1'b0);
			rdc(12'h000, {16'h0000, tab[i][15:0]});
			rdc(12'h004, {16'h0000, tab[i][31:16]});
			apb(12'h000, 1'b1, 32'h0000_0000);
			apb(12'h004, 1'b1, 32'h0000_0000);
			rdc(12'h000, 32'h0000_0000);
		end
		apb(12'h000, 1'b1, 32'hffff_ffff);
		rdc(12'h000, 32'h0000_7800);
		apb(12'h004, 1'b1, 32'hffff_ffff);
		rdc(12'h004, 32'h0000_c03e);
		apb(12'h004, 1'b1, 32'h0000_0000);
		fork
			apb(12'h000, 1'b1, 32'h0000_0000);
			begin
				@(posedge pclk);
				SRC.pulse(12'h001);
			end
		join
		rdc(12'h000, 32'h0000_4000);
		rdc(12'h008, 32'h0000_4000);
		apb(12'h000, 1'b1, 32'h0000_0000);
		apb(12'h00c, 1'b1, 32'h0000_0000);
		SRC.pulse(12'h200);
		irqc(1'b0);
		apb(12'h00c, 1'b1, 32'h0008_0000);
		@(posedge pclk);
		irqc(1'b1);
		rdc(12'h008, 32'h0008_0000);
		irqc(1'b0);
		apb(12'h008, 1'b1, 32'hffff_ffff);
		rdc(12'h008, 32'h0000_0000);
		apb(12'h010, 1'b1, 32'hffff_ffff);
		chk_bit(er, 1'b1);
		rdc(12'h010, 32'h0000_0000);
		chk_bit(er, 1'b1);
		end_sim;
	end
	initial
	begin
		#50000;
		miscompares++;
		end_sim;
	end
endmodule : interrupt_flag_status_bank_test
bind ifsb_bank ifsb_bank_chk #(.HAS_CAN(1'b0)) u_chk (.pclk, .presetn, .paddr, .psel,
	.penable, .pwrite, .pwdata, .pstrb, .pslverr, .calendar_clock_req, .dma_ch5_done_req,
	.codec_if_event_req, .codec_if_error_req, .audio_conv_right_req, .checksum_gen_req,
	.interrupt_flags_word_three, .interrupt_flags_word_four, .irq);
`default_nettype wire
